// ===== design/gpd_ports.sv
// Contract
// - Ordinary pins reset tri-stated; alt select, digital enable, pulls all zero.
// - The five debug pins reset with alt select, digital enable, pull-up set.
// - Power-on or external reset restores both pin groups to their defaults.
// - Port B bit 7 returns to the debug reset input after any reset.
// - Eight independent ports decoded by one loop; ports 4 and 7 carry only four pins.
// - Direction zero: pin is input, data bit captures the pad level.
// - Direction one: pin is output, data bit driven onto the pad.
// - Alt select set: peripheral controls the pin, not the data register.
`timescale 1ns/1ps
`default_nettype none
module gpd_ports #(
   parameter int PORT_COUNT = 8,
   parameter int PIN_COUNT = 8
) (
   // Clock and reset
   input wire logic core_clk,
   input wire logic sys_rst,
   // Configuration write
   input wire logic cfg_wr,
   input wire logic [gpd_pkg::GPD_PORT_W-1:0] cfg_port,
   input wire logic [2:0] cfg_field,
   input wire logic [7:0] cfg_wdata,
   // Configuration readback
   output logic [gpd_pkg::GPD_BITS-1:0] pin_data_value,
   output logic [gpd_pkg::GPD_BITS-1:0] pin_direction_ctl,
   output logic [gpd_pkg::GPD_BITS-1:0] alt_function_select,
   output logic [gpd_pkg::GPD_BITS-1:0] digital_pad_enable,
   output logic [gpd_pkg::GPD_BITS-1:0] pull_down_select,
   output logic [gpd_pkg::GPD_BITS-1:0] pull_up_select,
   // Pads
   input wire logic [gpd_pkg::GPD_BITS-1:0] pad_in,
   output logic [gpd_pkg::GPD_BITS-1:0] pad_out,
   output logic [gpd_pkg::GPD_BITS-1:0] pad_oe_n,
   // Alternate-function peripherals
   input wire logic [gpd_pkg::GPD_BITS-1:0] periph_out,
   input wire logic [gpd_pkg::GPD_BITS-1:0] periph_oe,
   output logic [gpd_pkg::GPD_BITS-1:0] periph_in,
   // Debug controller reset
   output logic jtag_trst_n
);
   import gpd_pkg::*;

   gpd_state_t st_ff;
   gpd_state_t nxt_st;
   logic [GPD_BITS-1:0] pad_sync;

   // ----------------------------------------------------------------
   // Elaboration checks
   // ----------------------------------------------------------------
   generate
      if (PORT_COUNT != GPD_PORTS) begin : g_bad_ports
         $error("gpd_ports: PORT_COUNT must match the package port count");
      end
      if (PIN_COUNT != GPD_PINS) begin : g_bad_pins
         $error("gpd_ports: PIN_COUNT must match the package pin count");
      end
   endgenerate

   // ----------------------------------------------------------------
   // Pad input synchroniser
   // ----------------------------------------------------------------
   gpd_sync #(
      .WIDTH(GPD_BITS)
   ) u_sync (
      .core_clk(core_clk),
      .sys_rst(sys_rst),
      .async_in(pad_in),
      .sync_out(pad_sync)
   );

   // ----------------------------------------------------------------
   // Configuration and data state
   // ----------------------------------------------------------------
   always_comb begin
      logic [7:0] wv;
      wv = 8'h00;
      nxt_st = st_ff;
      nxt_st.seen = 1'b1;
      // Every port decodes the same way; only its byte lane differs
      for (int p = 0; p < GPD_PORTS; p++) begin
         if (cfg_wr && (cfg_port == GPD_PORT_W'(p))) begin
            wv = cfg_wdata & GPD_PIN_MASK[p*GPD_PINS +: GPD_PINS];
            case (cfg_field)
               GPD_FLD_DATA: begin
                  nxt_st.data[p*GPD_PINS +: GPD_PINS] = wv;
               end
               GPD_FLD_DIR: begin
                  nxt_st.dir[p*GPD_PINS +: GPD_PINS] = wv;
               end
               GPD_FLD_AFSEL: begin
                  nxt_st.afsel[p*GPD_PINS +: GPD_PINS] = wv;
               end
               GPD_FLD_DEN: begin
                  nxt_st.den[p*GPD_PINS +: GPD_PINS] = wv;
               end
               GPD_FLD_PDR: begin
                  nxt_st.pdr[p*GPD_PINS +: GPD_PINS] = wv;
               end
               GPD_FLD_PUR: begin
                  nxt_st.pur[p*GPD_PINS +: GPD_PINS] = wv;
               end
               default: begin
               end
            endcase
         end
      end
      // Input pins track the pad; a software write to them is overwritten
      nxt_st.data = (nxt_st.data & st_ff.dir) | (pad_sync & ~st_ff.dir & GPD_PIN_MASK);
   end

   // One async reset serves both power-on and the external reset pin
   always_ff @(posedge core_clk or posedge sys_rst) begin
      if (sys_rst) begin
         st_ff.data <= GPD_DATA_RST;
         st_ff.dir <= GPD_DIR_RST;
         st_ff.afsel <= GPD_AFSEL_RST;
         st_ff.den <= GPD_DEN_RST;
         st_ff.pdr <= GPD_PDR_RST;
         st_ff.pur <= GPD_PUR_RST;
         st_ff.seen <= 1'b0;
      end else begin
         st_ff <= nxt_st;
      end
   end

   // ----------------------------------------------------------------
   // Pad multiplexing
   // ----------------------------------------------------------------
   generate
      for (genvar b = 0; b < GPD_BITS; b++) begin : g_pin
         if (GPD_PIN_MASK[b]) begin : g_impl
            always_comb begin
               if (st_ff.afsel[b]) begin
                  pad_out[b] = periph_out[b];
                  pad_oe_n[b] = ~periph_oe[b];
               end else begin
                  pad_out[b] = st_ff.data[b];
                  pad_oe_n[b] = ~st_ff.dir[b];
               end
            end
            assign periph_in[b] = pad_sync[b];
         end else begin : g_absent
            // Missing pins never drive and feed nothing back; procedural like the
            // implemented pins so no bit of the pad vectors mixes assignment kinds
            always_comb begin
               pad_out[b] = 1'b0;
               pad_oe_n[b] = 1'b1;
            end
            assign periph_in[b] = 1'b0;
         end
      end
   endgenerate

   // Reverting to the debug reset input means a low pad resets the debug
   // controller; the board must keep this pin high across reset
   assign jtag_trst_n = st_ff.afsel[GPD_TRST_BIT] ? pad_sync[GPD_TRST_BIT] : 1'b1;

   assign pin_data_value = st_ff.data;
   assign pin_direction_ctl = st_ff.dir;
   assign alt_function_select = st_ff.afsel;
   assign digital_pad_enable = st_ff.den;
   assign pull_down_select = st_ff.pdr;
   assign pull_up_select = st_ff.pur;

   // ----------------------------------------------------------------
   // Assertions
   // ----------------------------------------------------------------
   default clocking cb @(posedge core_clk);
   endclocking
   default disable iff (sys_rst);

   sequence s_dir_write;
      cfg_wr && (cfg_field == GPD_FLD_DIR);
   endsequence

   sequence s_dir_landed;
      ##1 (pin_direction_ctl[$past(cfg_port)*GPD_PINS +: GPD_PINS] ==
           ($past(cfg_wdata) & GPD_PIN_MASK[$past(cfg_port)*GPD_PINS +: GPD_PINS]));
   endsequence

   a_reset_tristate: assert property (!st_ff.seen |->
      (pin_direction_ctl == '0) && (pull_down_select == '0) &&
      ((alt_function_select | digital_pad_enable | pull_up_select) & ~GPD_DBG_MASK) == '0 &&
      ((pad_oe_n & ~GPD_DBG_MASK) == ~GPD_DBG_MASK))
      else $error("ordinary pins not at reset default");

   a_debug_defaults: assert property (!st_ff.seen |->
      ((alt_function_select & digital_pad_enable & pull_up_select & GPD_DBG_MASK) == GPD_DBG_MASK))
      else $error("debug pins not at reset default");

   a_reset_restores: assert property (!st_ff.seen |=> st_ff.seen &&
      $past(alt_function_select) == GPD_AFSEL_RST && $past(pin_data_value) == GPD_DATA_RST)
      else $error("reset did not restore defaults");

   a_trst_follow: assert property (
      alt_function_select[GPD_TRST_BIT] |-> (jtag_trst_n == pad_sync[GPD_TRST_BIT]))
      else $error("debug reset input does not follow pad");

   a_input_capture: assert property (1'b1 |=>
      ((pin_data_value & ~$past(pin_direction_ctl)) ==
       ($past(pad_sync) & ~$past(pin_direction_ctl) & GPD_PIN_MASK)))
      else $error("input pin did not capture pad");

   a_output_drive: assert property (
      ((pad_out ^ pin_data_value) & pin_direction_ctl & ~alt_function_select & GPD_PIN_MASK) == '0 &&
      (pad_oe_n & pin_direction_ctl & ~alt_function_select & GPD_PIN_MASK) == '0)
      else $error("output pin not driving data");

   a_alt_control: assert property (
      ((pad_out ^ periph_out) & alt_function_select) == '0 &&
      ((pad_oe_n ^ ~periph_oe) & alt_function_select) == '0)
      else $error("alternate pin not under peripheral control");

   a_unimpl_zero: assert property (
      ((pin_data_value | pin_direction_ctl | alt_function_select | digital_pad_enable |
        pull_down_select | pull_up_select) & ~GPD_PIN_MASK) == '0 && (pad_oe_n & ~GPD_PIN_MASK) == ~GPD_PIN_MASK)
      else $error("missing pin bit not zero");

   a_dir_write: assert property (s_dir_write |-> s_dir_landed)
      else $error("direction write did not land in its port");
endmodule
`default_nettype wire

// ===== inc/gpd_pkg.sv
`default_nettype none
// ----------------------------------------------------------------
// Port geometry
// ----------------------------------------------------------------
package gpd_pkg;
   localparam int GPD_PORTS = 8;
   localparam int GPD_PINS = 8;
   localparam int GPD_BITS = GPD_PORTS * GPD_PINS;
   localparam int GPD_PORT_W = 3;
   // One byte per port, port 0 in the low byte; ports 4 and 7 carry four pins
   localparam logic [63:0] GPD_PIN_MASK = 64'h0FFF_FF0F_FFFF_FFFF;
   // Debug-port pins: port 1 bit 7 and port 2 bits 3..0
   localparam logic [63:0] GPD_DBG_MASK = 64'h0000_0000_000F_8000;
   localparam int GPD_TRST_BIT = 15;
   // ----------------------------------------------------------------
   // Reset values
   // ----------------------------------------------------------------
   localparam logic [63:0] GPD_DATA_RST = 64'h0000_0000_0000_0000;
   localparam logic [63:0] GPD_DIR_RST = 64'h0000_0000_0000_0000;
   localparam logic [63:0] GPD_AFSEL_RST = GPD_DBG_MASK;
   localparam logic [63:0] GPD_DEN_RST = GPD_DBG_MASK;
   localparam logic [63:0] GPD_PDR_RST = 64'h0000_0000_0000_0000;
   localparam logic [63:0] GPD_PUR_RST = GPD_DBG_MASK;
   // ----------------------------------------------------------------
   // Configuration field select codes
   // ----------------------------------------------------------------
   localparam logic [2:0] GPD_FLD_DATA = 3'h0;
   localparam logic [2:0] GPD_FLD_DIR = 3'h1;
   localparam logic [2:0] GPD_FLD_AFSEL = 3'h2;
   localparam logic [2:0] GPD_FLD_DEN = 3'h3;
   localparam logic [2:0] GPD_FLD_PDR = 3'h4;
   localparam logic [2:0] GPD_FLD_PUR = 3'h5;

   typedef struct packed {
      logic [63:0] data;
      logic [63:0] dir;
      logic [63:0] afsel;
      logic [63:0] den;
      logic [63:0] pdr;
      logic [63:0] pur;
      logic seen;
   } gpd_state_t;
endpackage
`default_nettype wire

// ===== design/gpd_sync.sv
`timescale 1ns/1ps
`default_nettype none
// ----------------------------------------------------------------
// Two-stage pad synchroniser
// ----------------------------------------------------------------
module gpd_sync #(
   parameter int WIDTH = 64
) (
   // Clock and reset
   input wire logic core_clk,
   input wire logic sys_rst,
   // Pads in, synchronised copy out
   input wire logic [WIDTH-1:0] async_in,
   output logic [WIDTH-1:0] sync_out
);
   typedef struct packed {
      logic [WIDTH-1:0] s1_ff;
      logic [WIDTH-1:0] s2_ff;
   } gpd_sync_t;

   gpd_sync_t st_ff;
   gpd_sync_t nxt_st;

   generate
      if (WIDTH < 1) begin : g_bad
         $error("gpd_sync: WIDTH must be at least 1");
      end
   endgenerate

   // First stage feeds only the second stage
   always_comb begin
      nxt_st.s1_ff = async_in;
      nxt_st.s2_ff = st_ff.s1_ff;
   end

   always_ff @(posedge core_clk or posedge sys_rst) begin
      if (sys_rst) begin
         st_ff <= '0;
      end else begin
         st_ff <= nxt_st;
      end
   end

   assign sync_out = st_ff.s2_ff;
endmodule
`default_nettype wire

// ===== tb/gpd_pad_model.sv
`timescale 1ns/1ps
`default_nettype none
// ----------------------------------------------------------------
// Board circuitry on the pads
// ----------------------------------------------------------------
module gpd_pad_model (
   // Clock and reset
   input wire logic core_clk,
   input wire logic sys_rst,
   // Device side of the pads
   input wire logic [63:0] pad_out,
   input wire logic [63:0] pad_oe_n,
   input wire logic [63:0] pull_up_select,
   input wire logic [63:0] pull_down_select,
   // Board drive
   input wire logic [63:0] ext_val,
   input wire logic [63:0] ext_en,
   output logic [63:0] pad_in
);
   logic [63:0] last_ff;
   logic [63:0] drv_en;
   always_comb begin
      drv_en = ext_en;
      // Never pull the debug reset line low while the part resets
      if (sys_rst) drv_en[15] = 1'b0;
      for (int i = 0; i < 64; i++) begin
         if (!pad_oe_n[i]) pad_in[i] = pad_out[i];
         else if (drv_en[i]) pad_in[i] = ext_val[i];
         else if (pull_up_select[i]) pad_in[i] = 1'b1;
         else if (pull_down_select[i]) pad_in[i] = 1'b0;
         // Floating line keeps changing so a stale level is never trusted
         else pad_in[i] = ~last_ff[i];
      end
   end
   always_ff @(posedge core_clk or posedge sys_rst) begin
      if (sys_rst) last_ff <= 64'h0;
      else last_ff <= pad_in;
   end
endmodule
`default_nettype wire

// ===== tb/tb.sv
`timescale 1ns/1ps
`default_nettype none
module tb;
   import gpd_pkg::*;
   logic core_clk, sys_rst, cfg_wr, trst_n;
   logic [2:0] cfg_port, cfg_field;
   logic [7:0] cfg_wdata;
   logic [63:0] ext_val, ext_en, periph_out, periph_oe, pad_in, pad_out, oe_n;
   logic [63:0] pdv, dir, afs, den, pds, pus, pfi;
   int errors, checked;
   // Debug pins: port 1 bit 7, port 2 bits 3..0; missing pins of ports 4 and 7
   localparam logic [63:0] DBG = 64'h0000_0000_000F_8000;
   localparam logic [63:0] MISS = 64'hF000_00F0_0000_0000;
   initial begin
      core_clk = 1'b0;
      forever #20 core_clk = ~core_clk;
   end
   gpd_ports dut_u (.core_clk(core_clk), .sys_rst(sys_rst), .cfg_wr(cfg_wr), .cfg_port(cfg_port),
      .cfg_field(cfg_field), .cfg_wdata(cfg_wdata), .pin_data_value(pdv), .pin_direction_ctl(dir),
      .alt_function_select(afs), .digital_pad_enable(den), .pull_down_select(pds),
      .pull_up_select(pus), .pad_in(pad_in), .pad_out(pad_out), .pad_oe_n(oe_n),
      .periph_out(periph_out), .periph_oe(periph_oe), .periph_in(pfi), .jtag_trst_n(trst_n));
   gpd_pad_model pad_u (.core_clk(core_clk), .sys_rst(sys_rst), .pad_out(pad_out), .pad_oe_n(oe_n),
      .pull_up_select(pus), .pull_down_select(pds), .ext_val(ext_val), .ext_en(ext_en), .pad_in(pad_in));
   task chk64(input string nm, input logic [63:0] exp, input logic [63:0] got);
      checked++;
      if (got !== exp) begin
         errors++;
         $display("unexpected %s expected %h seen %h", nm, exp, got);
      end
   endtask
   task chk1(input string nm, input logic exp, input logic got);
      checked++;
      if (got !== exp) begin
         errors++;
         $display("unexpected %s expected %b seen %b", nm, exp, got);
      end
   endtask
   task wr(input logic [2:0] p, input logic [2:0] f, input logic [7:0] d);
      @(posedge core_clk);
      cfg_wr <= 1'b1;
      cfg_port <= p;
      cfg_field <= f;
      cfg_wdata <= d;
      @(posedge core_clk);
      cfg_wr <= 1'b0;
   endtask
   task dflt;
      chk64("direction", 64'h0, dir);
      chk64("data", 64'h0, pdv);
      chk64("alt select", DBG, afs);
      chk64("digital enable", DBG, den);
      chk64("pull down", 64'h0, pds);
      chk64("pull up", DBG, pus);
      chk64("drive enable", 64'hFFFF_FFFF_FFFF_FFFF, oe_n);
   endtask
   task conclude;
      $display("counts: checked %0d errors %0d", checked, errors);
      if (errors == 0 && checked > 0) $display("DONE - PASS");
      else $display("DONE - FAIL");
      $finish;
   endtask
   initial begin
      repeat (5000) @(posedge core_clk);
      errors++;
      conclude;
   end
   initial begin
      sys_rst = 1'b1; cfg_wr = 1'b0; cfg_port = 3'h0; cfg_field = 3'h0; cfg_wdata = 8'h0;
      ext_val = 64'h0; ext_en = 64'h0; periph_out = 64'h0; periph_oe = 64'h0;
      errors = 0; checked = 0;
      repeat (6) @(posedge core_clk);
      @(negedge core_clk);
      dflt;
      repeat (6) @(posedge core_clk);
      sys_rst <= 1'b0;
      repeat (2) @(posedge core_clk);
      @(negedge core_clk);
      chk1("debug reset", 1'b1, trst_n);
      $display("test reset defaults done");
      wr(3'h0, GPD_FLD_DIR, 8'hFF);
      wr(3'h0, GPD_FLD_DATA, 8'hA5);
      @(negedge core_clk);
      chk64("port 0 drive", 64'hA5, {56'h0, pad_out[7:0]});
      chk64("port 0 enable", 64'h0, {56'h0, oe_n[7:0]});
      @(posedge core_clk);
      ext_en <= 64'h0000_0000_FF00_0000;
      ext_val <= 64'h0000_0000_3C00_0000;
      // Write to input pins is lost to the pad capture
      wr(3'h3, GPD_FLD_DATA, 8'hFF);
      @(posedge core_clk);
      @(negedge core_clk);
      chk64("port 3 capture", 64'h3C, {56'h0, pdv[31:24]});
      chk64("peripheral input", 64'h3C, {56'h0, pfi[31:24]});
      $display("test direction done");
      wr(3'h4, GPD_FLD_DIR, 8'hFF);
      // Direction first, so the data write lands on output pins
      wr(3'h7, GPD_FLD_DIR, 8'hFF);
      wr(3'h7, GPD_FLD_DATA, 8'hFF);
      @(negedge core_clk);
      chk64("missing direction", 64'h0, dir & MISS);
      chk64("missing data", 64'h0, pdv & MISS);
      chk64("missing enable", MISS, oe_n & MISS);
      chk64("missing feedback", 64'h0, pfi & MISS);
      chk64("port 7 drive", 64'h0F00_0000_0000_0000, pad_out & 64'hFF00_0000_0000_0000);
      $display("test missing pins done");
      @(posedge core_clk);
      periph_out <= 64'h3;
      periph_oe <= 64'h5;
      wr(3'h0, GPD_FLD_AFSEL, 8'h0F);
      @(negedge core_clk);
      chk64("alt drive", 64'hA3, {56'h0, pad_out[7:0]});
      chk64("alt enable", 64'h0A, {56'h0, oe_n[7:0]});
      $display("test alternate function done");
      @(posedge core_clk);
      ext_en[15] <= 1'b1;
      repeat (2) @(posedge core_clk);
      @(negedge core_clk);
      chk1("debug reset low", 1'b0, trst_n);
      for (int f = 0; f < 6; f++) wr(3'h5, f[2:0], 8'hFF);
      wr(3'h1, GPD_FLD_AFSEL, 8'h00);
      wr(3'h2, GPD_FLD_PUR, 8'h00);
      // Reserved field code: must change nothing on port 3
      wr(3'h3, 3'h7, 8'hFF);
      @(negedge core_clk);
      chk1("debug reset released", 1'b1, trst_n);
      chk64("alt select before reset", 64'h0000_FF00_000F_000F, afs);
      chk64("pull up before reset", 64'h0000_FF00_0000_8000, pus);
      chk64("pull down before reset", 64'h0000_FF00_0000_0000, pds);
      chk64("digital enable before reset", 64'h0000_FF00_000F_8000, den);
      @(posedge core_clk);
      sys_rst <= 1'b1;
      repeat (2) @(posedge core_clk);
      @(negedge core_clk);
      dflt;
      @(posedge core_clk);
      sys_rst <= 1'b0;
      ext_en <= 64'h0;
      repeat (2) @(posedge core_clk);
      @(negedge core_clk);
      chk1("debug reset again", 1'b1, trst_n);
      $display("test second reset done");
      conclude;
   end
endmodule
`default_nettype wire
